/* File: core/pmicio_pkg.sv */
// pmicio_pkg: constants, register map and state type of the pmic i/o
// and push-button control block.
// assumes a 200 mhz pclk from which a 32 khz tick is derived.
package pmicio_pkg;

   // ------------------------------------------------------------
   // clock and tick
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 200_000_000; // pclk rate
   localparam int unsigned SLOW_HZ = 32768; // slow tick rate
   localparam int unsigned TICK_DIV = CLK_HZ / SLOW_HZ; // pclk per tick

   // ------------------------------------------------------------
   // button timing, in its own unit, then in slow ticks
   // ------------------------------------------------------------
   localparam int unsigned PRESS_ON_MS = 600; // hold to power up
   localparam int unsigned LONG_SHORT_S = 8; // long press, short select
   localparam int unsigned LONG_LONG_S = 15; // long press, long select
   localparam int unsigned PWRDN_MS = 500; // power-down sequence
   localparam int unsigned PRESS_ON_TICKS =
      (PRESS_ON_MS * SLOW_HZ + 999) / 1000;
   localparam int unsigned LONG_SHORT_TICKS = LONG_SHORT_S * SLOW_HZ;
   localparam int unsigned LONG_LONG_TICKS = LONG_LONG_S * SLOW_HZ;
   localparam int unsigned PWRDN_TICKS = (PWRDN_MS * SLOW_HZ + 999) / 1000;
   localparam logic [2:0] WAKE_TICKS = 3'h5; // about 150 us
   localparam int CNT_W = 20; // wide enough for 15 s of ticks
   localparam int DIV_W = 13; // wide enough for the tick divider

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CONFIG_OFS = 8'h00;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] BUCK_VOLT_OFS = 8'h10;

   // ------------------------------------------------------------
   // config fields
   // ------------------------------------------------------------
   localparam int CFG_MEM_RESET_SELECT = 0;
   localparam int CFG_DRIVE_TYPE = 1;
   localparam int CFG_CORE_RAIL_RESET = 2;
   localparam int CFG_LONG_SELECT = 3;
   localparam int CFG_FIRST_USER = 4;
   localparam int CFG_SECOND_USER = 5;
   localparam int CFG_THIRD_USER = 6;
   localparam int CFG_W = 7;
   // user bits default to released pins, everything else off
   localparam logic [6:0] CONFIG_RESET = 7'h70;

   // ------------------------------------------------------------
   // buck voltage codes and reset values
   // ------------------------------------------------------------
   localparam int BUCK_ONE_LSB = 0;
   localparam int BUCK_TWO_LSB = 8;
   localparam logic [5:0] BUCK_ONE_DEFAULT = 6'h10; // plain default
   localparam logic [5:0] BUCK_TWO_DEFAULT = 6'h10; // plain default

   // ------------------------------------------------------------
   // power state, one-hot
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_ACTIVE = 3'b010,
      ST_RESTART = 3'b100
   } pmicio_state_type;

endpackage

/* File: core/pmicio_edge_sampler.sv */
// pmicio_edge_sampler: samples a pin level on the slow tick through two
// flops and reports its level and one-cycle edge pulses.
// assumes din is synchronous to clk and tick is a one-cycle strobe.
`timescale 1ns/10ps
`default_nettype none
module pmicio_edge_sampler
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic tick,
   input wire logic din,
   output logic level,
   output logic fall,
   output logic rise
);
   logic s1_reg; // first stage, read only by second stage
   logic s2_reg; // settled level
   logic s3_reg; // level one tick ago

   // ------------------------------------------------------------
   // sampling chain
   // ------------------------------------------------------------
   // pins idle high, so reset to one avoids a false edge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end
      else if (ce && tick)
      begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // ------------------------------------------------------------
   // edges: qualified by tick so each edge is one pulse only
   // ------------------------------------------------------------
   assign level = s2_reg;
   assign fall = ce && tick && !s2_reg && s3_reg;
   assign rise = ce && tick && s2_reg && !s3_reg;
endmodule
`default_nettype wire

/* File: core/pmicio_tick_timer.sv */
// pmicio_tick_timer: counts slow ticks while run is high; a one-cycle
// done pulse when the limit is reached, then counting starts over.
// assumes limit is stable while run is high.
`timescale 1ns/10ps
`default_nettype none
module pmicio_tick_timer
   import pmicio_pkg::CNT_W;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic tick,
   input wire logic run,
   input wire logic [CNT_W-1:0] limit,
   output logic done
);
   logic [CNT_W-1:0] cnt_reg; // ticks counted so far
   logic [CNT_W-1:0] cnt_next;
   wire logic hit; // this tick completes the interval

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   assign hit = run && tick && (cnt_reg == limit - 1'b1);
   assign done = ce && hit;
   // a dropped run clears, so a partial interval never carries over
   assign cnt_next = !run ? '0 : hit ? '0 :
      tick ? cnt_reg + 1'b1 : cnt_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_reg <= '0;
      else if (ce)
         cnt_reg <= cnt_next;
   end
endmodule
`default_nettype wire

/* File: core/pmicio_top.sv */
// pmicio_top: i/o pin control and push-button logic of a pmic, with an
// apb register slave; pin outputs come straight from flops.
// assumes pins are synchronous to pclk and open-drain pull-ups outside.
//
// Contract
// - select 0: first pin open-drain from bit
// - select 1, good: second output follows first
// - select 1, not good: latched, low after reset
// - select 0: second output from user bit
// - select 1: bit ignored, drive type kept
// - rail reset off: third pin open-drain
// - third pin fall restores both buck codes
// - buck rails ramp back without power cycle
// - power up after 600 ms button hold
// - active: interrupt on each button change
// - readable bit shows present button level
// - active: wake low five ticks on fall
// - long press disables rails, enters restart
// - restart powers up after 500 ms
// - held button repeats restart each interval
// - event sets bit, pin low, read clears
// - event in read-clear cycle keeps bit set
// - mask gates only the interrupt pin
`timescale 1ns/10ps
`default_nettype none
module pmicio_top
   import pmicio_pkg::*;
#(
   parameter int unsigned TICK_DIV_P = TICK_DIV,
   parameter int unsigned PRESS_ON_TICKS_P = PRESS_ON_TICKS,
   parameter int unsigned LONG_SHORT_TICKS_P = LONG_SHORT_TICKS,
   parameter int unsigned LONG_LONG_TICKS_P = LONG_LONG_TICKS,
   parameter int unsigned PWRDN_TICKS_P = PWRDN_TICKS
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_good,
   input wire logic push_button,
   input wire logic seq_first_low,
   input wire logic seq_third_low,
   input wire logic first_io_pin_in,
   output logic first_io_pin_out,
   output logic first_io_pin_oe_n,
   output logic second_output_out,
   output logic second_output_oe_n,
   input wire logic third_io_pin_in,
   output logic third_io_pin_out,
   output logic third_io_pin_oe_n,
   output logic wake_request_n_out,
   output logic wake_request_n_oe_n,
   output logic irq_n_out,
   output logic irq_n_oe_n,
   output logic power_up_req,
   output logic rails_down_req,
   output logic restart_state,
   output logic [5:0] buck_rail_one_code,
   output logic [5:0] buck_rail_two_code
);
   import pmicio_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [DIV_W-1:0] div_reg; // tick divider
   logic tick_reg; // one pclk per slow period
   logic [CFG_W-1:0] cfg_reg; // config register
   logic mask_reg; // button_irq_mask
   logic irq_stat_reg; // sticky button event
   logic [5:0] buck_one_reg; // buck_rail_one code
   logic [5:0] buck_two_reg; // buck_rail_two code
   logic ddr_hold_reg; // second output value kept when not good
   logic [2:0] wake_cnt_reg; // wake pulse ticks left
   pmicio_state_type state_reg; // power state
   pmicio_state_type state_next;
   wire logic btn_level; // sampled button level
   wire logic btn_fall;
   wire logic btn_rise;
   wire logic third_fall; // sampled third pin falling edge
   wire logic press_on_done; // 600 ms hold reached
   wire logic long_done; // long-press interval reached
   wire logic pwrdn_done; // power-down sequence over
   wire logic [CNT_W-1:0] long_limit;
   wire logic sel_mem; // first pin is memory-reset input
   wire logic apb_setup; // setup cycle of a transfer
   wire logic apb_done; // access completes this edge
   wire logic wr_en;
   wire logic rd_clear; // read of irq status completes
   wire logic btn_event; // button change in active state
   wire logic addr_hit; // address maps to a register
   wire logic [31:0] rd_mux;
   wire logic second_value; // level the second output presents
   wire logic second_drive_n; // second output enable, low drives

   // decode of the register offsets, shared by read and write paths
   function automatic logic is_ofs(input logic [7:0] a,
                                   input logic [7:0] ofs);
      is_ofs = (a == ofs);
   endfunction

   // ------------------------------------------------------------
   // slow tick from pclk
   // ------------------------------------------------------------
   // a divider keeps one clock domain; the tick is a strobe only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end
      else if (ce)
      begin
         tick_reg <= (div_reg == DIV_W'(TICK_DIV_P - 1));
         div_reg <= (div_reg == DIV_W'(TICK_DIV_P - 1)) ? '0 :
            div_reg + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // input sampling and timers
   // ------------------------------------------------------------
   // button sampled on the slow tick, one pulse per edge
   pmicio_edge_sampler u_btn (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .tick(tick_reg),
      .din(push_button),
      .level(btn_level),
      .fall(btn_fall),
      .rise(btn_rise)
   );

   // third pin sampled the same way for the rail reset
   pmicio_edge_sampler u_third (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .tick(tick_reg),
      .din(third_io_pin_in),
      .level(),
      .fall(third_fall),
      .rise()
   );

   // hold-to-power-up timer, only while off and held low
   pmicio_tick_timer u_press_on (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .tick(tick_reg),
      .run(state_reg == ST_OFF && !btn_level),
      .limit(CNT_W'(PRESS_ON_TICKS_P)),
      .done(press_on_done)
   );

   // long press keeps counting across restarts while held
   assign long_limit = cfg_reg[CFG_LONG_SELECT] ?
      CNT_W'(LONG_LONG_TICKS_P) : CNT_W'(LONG_SHORT_TICKS_P);
   pmicio_tick_timer u_long (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .tick(tick_reg),
      .run(state_reg != ST_OFF && !btn_level),
      .limit(long_limit),
      .done(long_done)
   );

   // power-down sequence timer in restart state
   pmicio_tick_timer u_pwrdn (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .tick(tick_reg),
      .run(state_reg == ST_RESTART),
      .limit(CNT_W'(PWRDN_TICKS_P)),
      .done(pwrdn_done)
   );

   // ------------------------------------------------------------
   // power state machine
   // ------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF:
            if (press_on_done)
               state_next = ST_ACTIVE;
         ST_ACTIVE:
            if (long_done)
               state_next = ST_RESTART;
         ST_RESTART:
            // restart ends on time, button level ignored
            if (pwrdn_done)
               state_next = ST_ACTIVE;
         default:
            state_next = ST_OFF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_OFF;
         power_up_req <= 1'b0;
         rails_down_req <= 1'b0;
         restart_state <= 1'b0;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         // one-cycle requests to the rail sequencer
         power_up_req <= (state_reg != ST_ACTIVE) &&
            (state_next == ST_ACTIVE);
         rails_down_req <= (state_reg == ST_ACTIVE) &&
            (state_next == ST_RESTART);
         restart_state <= (state_next == ST_RESTART);
      end
   end

   // ------------------------------------------------------------
   // apb slave: no wait states, registered answer
   // ------------------------------------------------------------
   assign apb_setup = psel && !penable;
   assign apb_done = psel && penable && pready;
   assign wr_en = apb_done && pwrite && addr_hit;
   assign rd_clear = apb_done && !pwrite &&
      is_ofs(paddr, IRQ_STATUS_OFS);
   assign addr_hit = is_ofs(paddr, CONFIG_OFS) ||
      is_ofs(paddr, IRQ_MASK_OFS) || is_ofs(paddr, IRQ_STATUS_OFS) ||
      is_ofs(paddr, STATUS_OFS) || is_ofs(paddr, BUCK_VOLT_OFS);
   assign rd_mux =
      is_ofs(paddr, CONFIG_OFS) ? {25'h0, cfg_reg} :
      is_ofs(paddr, IRQ_MASK_OFS) ? {31'h0, mask_reg} :
      is_ofs(paddr, IRQ_STATUS_OFS) ? {31'h0, irq_stat_reg} :
      is_ofs(paddr, STATUS_OFS) ?
         {25'h0, state_reg, third_io_pin_in, first_io_pin_in,
          power_good, btn_level} :
      is_ofs(paddr, BUCK_VOLT_OFS) ?
         {18'h0, buck_two_reg, 2'h0, buck_one_reg} : 32'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else if (ce)
      begin
         // ready rises in the access phase, drops after it
         pready <= apb_setup;
         pslverr <= apb_setup && !addr_hit;
         if (apb_setup)
            prdata <= pwrite ? 32'h0 : rd_mux;
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_reg <= CONFIG_RESET;
         mask_reg <= 1'b0;
      end
      else if (ce && wr_en)
      begin
         if (is_ofs(paddr, CONFIG_OFS))
            cfg_reg <= pwdata[CFG_W-1:0];
         if (is_ofs(paddr, IRQ_MASK_OFS))
            mask_reg <= pwdata[0];
      end
   end

   // buck codes: the third pin fall beats a software write so a
   // host in reset always gets known voltages back
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         buck_one_reg <= BUCK_ONE_DEFAULT;
         buck_two_reg <= BUCK_TWO_DEFAULT;
      end
      else if (ce)
      begin
         if (cfg_reg[CFG_CORE_RAIL_RESET] && third_fall)
         begin
            buck_one_reg <= BUCK_ONE_DEFAULT;
            buck_two_reg <= BUCK_TWO_DEFAULT;
         end
         else if (wr_en && is_ofs(paddr, BUCK_VOLT_OFS))
         begin
            buck_one_reg <= pwdata[BUCK_ONE_LSB +: 6];
            buck_two_reg <= pwdata[BUCK_TWO_LSB +: 6];
         end
      end
   end

   // ------------------------------------------------------------
   // button interrupt and wake pulse
   // ------------------------------------------------------------
   assign btn_event = (state_reg == ST_ACTIVE) && (btn_fall || btn_rise);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_reg <= 1'b0;
         wake_cnt_reg <= 3'h0;
      end
      else if (ce)
      begin
         // set wins over the read clear, so no change is lost
         if (btn_event)
            irq_stat_reg <= 1'b1;
         else if (rd_clear)
            irq_stat_reg <= 1'b0;
         if (state_reg == ST_ACTIVE && btn_fall)
            wake_cnt_reg <= WAKE_TICKS;
         else if (tick_reg && wake_cnt_reg != 3'h0)
            wake_cnt_reg <= wake_cnt_reg - 1'b1;
      end
   end

   // ------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------
   assign sel_mem = cfg_reg[CFG_MEM_RESET_SELECT];
   // select 1: follow the first pin while good, else keep the hold
   assign second_value = sel_mem ?
      (power_good ? first_io_pin_in : ddr_hold_reg) :
      cfg_reg[CFG_SECOND_USER];
   // push-pull always drives; open-drain only drives a low
   assign second_drive_n = cfg_reg[CFG_DRIVE_TYPE] ? 1'b0 :
      second_value;

   // hold starts low from reset and tracks the pin while good, so it
   // carries the level seen when power_good falls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ddr_hold_reg <= 1'b0;
      else if (ce && power_good)
         ddr_hold_reg <= first_io_pin_in;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         first_io_pin_out <= 1'b0;
         first_io_pin_oe_n <= 1'b1;
         second_output_out <= 1'b0;
         second_output_oe_n <= 1'b1;
         third_io_pin_out <= 1'b0;
         third_io_pin_oe_n <= 1'b1;
         wake_request_n_out <= 1'b0;
         wake_request_n_oe_n <= 1'b1;
         irq_n_out <= 1'b0;
         irq_n_oe_n <= 1'b1;
      end
      else if (ce)
      begin
         // open-drain pins only ever pull low
         first_io_pin_oe_n <= sel_mem ||
            (cfg_reg[CFG_FIRST_USER] && !seq_first_low);
         second_output_out <= second_value;
         second_output_oe_n <= second_drive_n;
         third_io_pin_oe_n <= cfg_reg[CFG_CORE_RAIL_RESET] ||
            (cfg_reg[CFG_THIRD_USER] && !seq_third_low);
         wake_request_n_oe_n <= (wake_cnt_reg == 3'h0);
         // mask gates the pin only, the sticky bit still sets
         irq_n_oe_n <= !(irq_stat_reg && !mask_reg);
      end
   end

   // the rails slew back from these codes with no power cycle
   assign buck_rail_one_code = buck_one_reg;
   assign buck_rail_two_code = buck_two_reg;
endmodule
`default_nettype wire

/* File: test/pmicio_properties.sv */
// pmicio_properties: port-level checks for pmicio_top.
// assumes only the top ports are visible; bound in below.
`timescale 1ns/10ps
`default_nettype none
module pmicio_properties
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic first_io_pin_out,
   input wire logic third_io_pin_out,
   input wire logic wake_request_n_out,
   input wire logic wake_request_n_oe_n,
   input wire logic irq_n_out,
   input wire logic irq_n_oe_n,
   input wire logic power_up_req,
   input wire logic rails_down_req,
   input wire logic restart_state
);
   // ---------------------------------------------
   // checks, one clock domain
   // ---------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_next: assert property (
      ce && psel && !penable |=> pready) else $error("no ready");
   a_ready_pulse: assert property (
      pready && ce |=> !pready) else $error("ready too long");
   a_err_unmapped: assert property (
      psel && penable && pready && paddr > 8'h10 |-> pslverr && prdata == 0)
      else $error("unmapped not refused");
   // open-drain drivers only ever pull low
   a_od_low: assert property (
      !(first_io_pin_out | third_io_pin_out | wake_request_n_out | irq_n_out))
      else $error("open-drain drives high");
   a_irq_clear: assert property (
      psel && penable && pready && !pwrite && paddr == 8'h08
      |=> ##1 irq_n_oe_n) else $error("irq not released");
   a_wake_hold: assert property (
      $fell(wake_request_n_oe_n) |-> !wake_request_n_oe_n [*8])
      else $error("wake too short");
   a_up_pulse: assert property (
      power_up_req && ce |=> !power_up_req) else $error("up pulse long");
   a_down_enters: assert property (
      rails_down_req |-> ##[0:1] restart_state) else $error("no restart");
   // past guard skips the drop at reset
   a_restart_exit: assert property (
      $fell(restart_state) && $past(presetn) |-> ##[0:1] power_up_req)
      else $error("no power up after restart");
endmodule
bind pmicio_top pmicio_properties u_props (.*);
`default_nettype wire

/* File: test/pmicio_host_model.sv */
// pmicio_host_model: host memory-reset driver and push button.
// assumes board pull-ups on every open-drain pin.
`timescale 1ns/10ps
`default_nettype none
module pmicio_host_model
(
   input wire logic press, // button held
   input wire logic mem_rst, // host memory-reset level
   input wire logic host_on, // host drives first pin
   input wire logic third_low, // host pulls third pin
   input wire logic first_oe_n,
   input wire logic third_oe_n,
   output logic push_button,
   output logic first_pin,
   output logic third_pin
);
   // switch to ground, pull-up when open
   assign push_button = !press;
   // wired-and of both parties; pull-up wins when nobody drives
   assign first_pin = (host_on ? mem_rst : 1'b1) & first_oe_n;
   assign third_pin = !third_low & third_oe_n;
endmodule
`default_nettype wire

/* File: test/pmicio_top_tb.sv */
// pmicio_top_tb: apb-driven tests of pins, button and restart.
// assumes shrunk tick counts so the run stays short.
`timescale 1ns/10ps
`default_nettype none
module pmicio_top_tb;
   import pmicio_pkg::*;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   logic power_good = 1'b0, seq_first_low = 1'b0, seq_third_low = 1'b0;
   logic press = 1'b0, mem_rst = 1'b1, host_on = 1'b0, third_low = 1'b0;
   logic push_button, first_io_pin_in, third_io_pin_in;
   logic first_io_pin_out, first_io_pin_oe_n, second_output_out;
   logic second_output_oe_n, third_io_pin_out, third_io_pin_oe_n;
   logic wake_request_n_out, wake_request_n_oe_n, irq_n_out, irq_n_oe_n;
   logic power_up_req, rails_down_req, restart_state;
   logic [5:0] buck_rail_one_code, buck_rail_two_code;
   int n_errors = 0, n_compared = 0, n;
   always #2.5 pclk = ~pclk;
   pmicio_top #(.TICK_DIV_P(4), .PRESS_ON_TICKS_P(6), .LONG_SHORT_TICKS_P(20),
      .LONG_LONG_TICKS_P(30), .PWRDN_TICKS_P(5)) dut (.*);
   pmicio_host_model host (.press(press), .mem_rst(mem_rst),
      .host_on(host_on), .third_low(third_low),
      .first_oe_n(first_io_pin_oe_n), .third_oe_n(third_io_pin_oe_n),
      .push_button(push_button), .first_pin(first_io_pin_in),
      .third_pin(third_io_pin_in));
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic complete_run();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s exp %h got %h", s, exp, got);
      end
   endtask
   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
      if (pready !== 1'b1) n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input string s);
      apb(1'b0, a, 32'h0);
      chk(s, rd, e);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // bounded waits, n counts cycles
   task automatic wake(input logic lv);
      n = 0;
      while (wake_request_n_oe_n !== lv && n < 60)
      begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic hold(input logic lv);
      n = 0;
      while (restart_state !== lv && n < 200)
      begin
         @(posedge pclk);
         n++;
      end
   endtask
   // ---------------------------------------------
   // watchdog and tests
   // ---------------------------------------------
   initial
   begin
      cyc(5000);
      n_errors++;
      complete_run();
   end
   initial
   begin
      cyc(6);
      presetn <= 1'b1;
      rdc(CONFIG_OFS, 32'h70, "config");
      rdc(BUCK_VOLT_OFS, 32'h1010, "buck");
      rdc(8'h20, 32'h0, "unmapped");
      chk("slverr", err, 1);
      wr(CONFIG_OFS, 32'h0);
      cyc(2);
      chk("pins low", {first_io_pin_oe_n, third_io_pin_oe_n,
         second_output_oe_n, second_output_out}, 0);
      wr(CONFIG_OFS, 32'h72);
      cyc(2);
      chk("pins high", {first_io_pin_oe_n, third_io_pin_oe_n,
         second_output_oe_n, second_output_out}, 4'hd);
      // memory-reset path, push-pull, user bit ignored
      host_on <= 1'b1;
      power_good <= 1'b1;
      wr(CONFIG_OFS, 32'h03);
      cyc(2);
      chk("follow high", {first_io_pin_oe_n, second_output_oe_n,
         second_output_out}, 3'h5);
      mem_rst <= 1'b0;
      cyc(3);
      chk("follow low", second_output_out, 0);
      mem_rst <= 1'b1;
      cyc(3);
      power_good <= 1'b0;
      cyc(2);
      mem_rst <= 1'b0;
      cyc(3);
      chk("latched", second_output_out, 1);
      // third pin as buck code reset
      wr(BUCK_VOLT_OFS, 32'h0505);
      wr(CONFIG_OFS, 32'h44);
      cyc(12);
      third_low <= 1'b1;
      cyc(20);
      rdc(BUCK_VOLT_OFS, 32'h1010, "buck back");
      chk("codes", {buck_rail_one_code, buck_rail_two_code}, 12'h410);
      rdc(CONFIG_OFS, 32'h44, "config kept");
      third_low <= 1'b0;
      // power up, then button change interrupts
      press <= 1'b1;
      cyc(44);
      rdc(STATUS_OFS, 32'h28, "active");
      rdc(IRQ_STATUS_OFS, 32'h0, "no irq off");
      press <= 1'b0;
      cyc(20);
      chk("irq pin", irq_n_oe_n, 0);
      rdc(IRQ_STATUS_OFS, 32'h1, "irq set");
      cyc(2);
      chk("irq off", irq_n_oe_n, 1);
      rdc(STATUS_OFS, 32'h29, "level");
      press <= 1'b1;
      wake(1'b0);
      wake(1'b1);
      chk("wake len", n >= 19 && n <= 25, 1);
      rdc(IRQ_STATUS_OFS, 32'h1, "fall irq");
      wr(IRQ_MASK_OFS, 32'h1);
      press <= 1'b0;
      cyc(20);
      chk("masked pin", irq_n_oe_n, 1);
      rdc(IRQ_STATUS_OFS, 32'h1, "masked bit");
      wr(IRQ_MASK_OFS, 32'h0);
      // long press for both interval selects
      for (int i = 0; i < 2; i++)
      begin
         press <= 1'b0;
         cyc(30);
         wr(CONFIG_OFS, 32'h44 | (i << 3));
         press <= 1'b1;
         hold(1'b1);
         chk("long", n >= 80 + 40 * i && n <= 96 + 40 * i, 1);
         hold(1'b0);
         chk("restart", n >= 18 && n <= 26, 1);
      end
      hold(1'b1);
      chk("again", restart_state, 1);
      complete_run();
   end
endmodule
`default_nettype wire
